/* File: rvc_adc_model.sv */
// converter model: sample clock, syncs and a known pixel pattern
module rvc_adc_model (
    // pins toward the capture block
    output logic        sclk_out,
    output logic        vs_out,
    output logic        hs_out,
    output logic [23:0] abc_out,
    output logic [23:0] def_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle pins: clock stopped, syncs low
    initial begin
        sclk_out = 1'b0;
        vs_out   = 1'b0;
        hs_out   = 1'b0;
        abc_out  = 24'h00_0000;
        def_out  = 24'h00_0000;
    end
    // sample clock period set here
    // kept slow on purpose so two-flop sampling at 8 ns sees every phase
    // first pixel before rise, second before fall
    task automatic tick(input logic [23:0] a, input logic [23:0] d);
        abc_out = a;
        #80 sclk_out = 1'b1;
        def_out = d;
        #80 sclk_out = 1'b0;
    endtask
    // clock made here, running only within frames
    task automatic send_frame(input bit with_vs, input int lines);
        #2 vs_out = with_vs;
        #400 vs_out = 1'b0;
        for (int l = 1; l <= lines; l++) begin
            hs_out = 1'b1;
            repeat (2) tick(~abc_out, ~def_out);
            hs_out = 1'b0;
            // second pixel of each pair on the other ports
            for (int k = 0; k < 8; k++) tick({8'(l), 8'(k), 8'h5a}, {8'(k), 8'(l), 8'hc3});
        end
        repeat (2) tick(~abc_out, ~def_out);
    endtask
endmodule // rvc_adc_model

/* File: rvc_capture.sv */
// rgb video input capture: pin sampling, sync framing, window, adc calibration
`include "rvc_defs.svh"

module rvc_capture #(
    parameter int CNT_W = `RVC_CNT_W,
    parameter int PIX_W = `RVC_PIX_W
) (
    // system clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    // video pins from the converters
    input  wire logic             input_sample_clock_in,
    input  wire logic [7:0]       first_pixel_red_port_in,
    input  wire logic [7:0]       first_pixel_green_port_in,
    input  wire logic [7:0]       first_pixel_blue_port_in,
    input  wire logic [7:0]       second_pixel_red_port_in,
    input  wire logic [7:0]       second_pixel_green_port_in,
    input  wire logic [7:0]       second_pixel_blue_port_in,
    input  wire logic             vertical_sync_input_in,
    input  wire logic             horizontal_sync_input_in,
    // configuration
    input  wire logic             double_mode_in,
    input  wire logic [CNT_W-1:0] h_offset_in,
    input  wire logic [CNT_W-1:0] v_offset_in,
    input  wire logic [CNT_W-1:0] h_size_in,
    input  wire logic [CNT_W-1:0] v_size_in,
    input  wire logic             overflow_clr_in,
    // pixel stream out
    input  wire logic             pix_ready_in,
    output logic      [PIX_W-1:0] pix_data_out,
    output logic                  pix_valid_out,
    // converter calibration and status
    output logic                  adc_clamp_pulse_out,
    output logic                  adc_gain_cal_pulse_out,
    output logic                  frame_locked_out,
    output logic                  overflow_out
);
    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic [1:0]            rst_sync_r;
    logic                  rst_b;
    logic [`RVC_PIN_W-1:0] pin_s1_r;
    logic [`RVC_PIN_W-1:0] pin_s2_r;
    logic                  sclk_prev_r;
    logic [`RVC_PIN_W-1:0] pin_raw;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  vs_prev_r;
    logic                  hs_prev_r;
    logic                  vs_fall;
    logic                  hs_fall;

    assign pin_raw = {input_sample_clock_in, vertical_sync_input_in,
                      horizontal_sync_input_in,
                      second_pixel_red_port_in, second_pixel_green_port_in,
                      second_pixel_blue_port_in,
                      first_pixel_red_port_in, first_pixel_green_port_in,
                      first_pixel_blue_port_in};

    // reset released through two flops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    // external clock sampled
    // two-flop sampling of every pin; stage one feeds only stage two
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r    <= '0;
            pin_s2_r    <= '0;
            sclk_prev_r <= 1'b0;
            vs_prev_r   <= 1'b0;
            hs_prev_r   <= 1'b0;
        end else begin
            pin_s1_r    <= pin_raw;
            pin_s2_r    <= pin_s1_r;
            sclk_prev_r <= pin_s2_r[`RVC_POS_SCLK];
            vs_prev_r   <= pin_s2_r[`RVC_POS_VS];
            hs_prev_r   <= pin_s2_r[`RVC_POS_HS];
        end
    end

    assign sclk_rise = pin_s2_r[`RVC_POS_SCLK] & ~sclk_prev_r;
    assign sclk_fall = ~pin_s2_r[`RVC_POS_SCLK] & sclk_prev_r;
    assign vs_fall   = ~pin_s2_r[`RVC_POS_VS] & vs_prev_r;
    assign hs_fall   = ~pin_s2_r[`RVC_POS_HS] & hs_prev_r;

    // ****************************************************************
    // window counters, pixel assembly, calibration pulses
    // ****************************************************************
    // true when cnt lies in [off, off+size)
    function automatic logic in_win(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] off,
                                    input logic [CNT_W-1:0] size);
        logic [CNT_W:0] lim;
        lim    = {1'b0, off} + {1'b0, size};
        in_win = (cnt >= off) && ({1'b0, cnt} < lim);
    endfunction

    logic [CNT_W-1:0]          h_cnt_r;
    logic [CNT_W-1:0]          h_cnt_nxt;
    logic [CNT_W-1:0]          v_cnt_r;
    logic [CNT_W-1:0]          v_cnt_nxt;
    logic                      locked_r;
    logic                      locked_nxt;
    logic                      pair_win_r;
    logic                      pair_win_nxt;
    logic [`RVC_ONE_PIX_W-1:0] first_r;
    logic [`RVC_ONE_PIX_W-1:0] first_nxt;
    logic [`RVC_PULSE_W-1:0]   clamp_cnt_r;
    logic [`RVC_PULSE_W-1:0]   clamp_cnt_nxt;
    logic [`RVC_PULSE_W-1:0]   gain_cnt_r;
    logic [`RVC_PULSE_W-1:0]   gain_cnt_nxt;
    logic                      clamp_r;
    logic                      gain_r;
    logic                      ovf_r;
    logic                      ovf_nxt;
    logic                      win_now;
    logic                      push_v;
    logic [PIX_W-1:0]          push_d;
    rvc_pkg::rvc_mode_t        mode;

    rvc_pix_if #(.W(PIX_W)) fill_if ();
    rvc_pix_if #(.W(PIX_W)) drain_if ();

    assign mode    = rvc_pkg::rvc_mode_t'(double_mode_in);
    assign win_now = locked_r && in_win(h_cnt_r, h_offset_in, h_size_in)
                     && in_win(v_cnt_r, v_offset_in, v_size_in);

    // next counter, pixel and pulse state
    always_comb begin
        h_cnt_nxt     = h_cnt_r;
        v_cnt_nxt     = v_cnt_r;
        locked_nxt    = locked_r;
        pair_win_nxt  = pair_win_r;
        first_nxt     = first_r;
        clamp_cnt_nxt = clamp_cnt_r;
        gain_cnt_nxt  = gain_cnt_r;
        push_v        = 1'b0;
        push_d        = '0;
        if (sclk_rise && (h_cnt_r != {CNT_W{1'b1}})) begin
            h_cnt_nxt = h_cnt_r + 1'b1;
        end
        // calibration pulses last a fixed number of sample clocks
        if (sclk_rise && (clamp_cnt_r != '0)) begin
            clamp_cnt_nxt = clamp_cnt_r - 1'b1;
        end
        if (sclk_rise && (gain_cnt_r != '0)) begin
            gain_cnt_nxt = gain_cnt_r - 1'b1;
        end
        if (hs_fall) begin
            h_cnt_nxt     = '0;
            clamp_cnt_nxt = `RVC_CLAMP_LEN;
            if (v_cnt_r != {CNT_W{1'b1}}) begin
                v_cnt_nxt = v_cnt_r + 1'b1;
            end
        end
        if (vs_fall) begin
            v_cnt_nxt    = '0;
            locked_nxt   = 1'b1;
            gain_cnt_nxt = `RVC_GAIN_LEN;
        end
        if (sclk_rise) begin
            first_nxt    = pin_s2_r[`RVC_ONE_PIX_W-1:0];
            pair_win_nxt = win_now;
        end
        case (mode)
            // single mode uses first pixel only
            rvc_pkg::RVC_SINGLE: begin
                push_v = sclk_rise && win_now;
                push_d = {{(PIX_W-`RVC_ONE_PIX_W){1'b0}},
                          pin_s2_r[`RVC_ONE_PIX_W-1:0]};
            end
            // second pixel taken on falling edge
            rvc_pkg::RVC_DOUBLE: begin
                push_v = sclk_fall && pair_win_r;
                push_d = {pin_s2_r[`RVC_POS_HS-1:`RVC_POS_SECOND], first_r};
            end
            default: begin
                push_v = 1'b0;
            end
        endcase
        // a stalled word is dropped and flagged; set beats clear
        ovf_nxt = (ovf_r && !overflow_clr_in) || (push_v && !fill_if.ready);
    end

    assign fill_if.valid  = push_v;
    assign fill_if.data   = push_d;
    assign drain_if.ready = pix_ready_in;

    // counter and pulse registers
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            h_cnt_r     <= '0;
            v_cnt_r     <= '0;
            locked_r    <= 1'b0;
            pair_win_r  <= 1'b0;
            first_r     <= '0;
            clamp_cnt_r <= '0;
            gain_cnt_r  <= '0;
            clamp_r     <= 1'b0;
            gain_r      <= 1'b0;
            ovf_r       <= 1'b0;
        end else begin
            h_cnt_r     <= h_cnt_nxt;
            v_cnt_r     <= v_cnt_nxt;
            locked_r    <= locked_nxt;
            pair_win_r  <= pair_win_nxt;
            first_r     <= first_nxt;
            clamp_cnt_r <= clamp_cnt_nxt;
            gain_cnt_r  <= gain_cnt_nxt;
            clamp_r     <= (clamp_cnt_nxt != '0);
            gain_r      <= (gain_cnt_nxt != '0);
            ovf_r       <= ovf_nxt;
        end
    end

    // ****************************************************************
    // output buffer and status
    // ****************************************************************
    rvc_skid_buf #(
        .W (PIX_W)
    ) u_buf (
        .clk_in   (clk_in),
        .rst_b_in (rst_b),
        .in_if    (fill_if.snk),
        .out_if   (drain_if.src)
    );

    assign pix_data_out           = drain_if.data;  // buffer head register
    assign pix_valid_out          = drain_if.valid; // buffer head register
    assign adc_clamp_pulse_out    = clamp_r;
    assign adc_gain_cal_pulse_out = gain_r;
    assign frame_locked_out       = locked_r;
    assign overflow_out           = ovf_r;
endmodule // rvc_capture

/* File: rvc_capture_props.sv */
// assertions on the top-level ports of the capture block
module rvc_capture_props #(
    parameter int PIX_W = 48
) (
    // clock and reset
    input wire logic             clk_in,
    input wire logic             rst_b_in,
    // watched inputs
    input wire logic             input_sample_clock_in,
    input wire logic             vertical_sync_input_in,
    input wire logic             double_mode_in,
    input wire logic             overflow_clr_in,
    input wire logic             pix_ready_in,
    // watched outputs
    input wire logic [PIX_W-1:0] pix_data_out,
    input wire logic             pix_valid_out,
    input wire logic             adc_clamp_pulse_out,
    input wire logic             adc_gain_cal_pulse_out,
    input wire logic             frame_locked_out,
    input wire logic             overflow_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sclk_q_r;
    logic       sclk_rise;
    logic [4:0] clamp_n_r;
    logic [4:0] clamp_n_nxt;
    logic [4:0] gain_n_r;
    logic [4:0] gain_n_nxt;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // count sample clock rises while each calibration pulse is high
    always_comb begin
        sclk_rise   = input_sample_clock_in & ~sclk_q_r;
        clamp_n_nxt = adc_clamp_pulse_out ? clamp_n_r + 5'(sclk_rise) : 5'h0;
        gain_n_nxt  = adc_gain_cal_pulse_out ? gain_n_r + 5'(sclk_rise) : 5'h0;
    end
    // register the rise counters
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sclk_q_r  <= 1'b0;
            clamp_n_r <= 5'h0;
            gain_n_r  <= 5'h0;
        end else begin
            sclk_q_r  <= input_sample_clock_in;
            clamp_n_r <= clamp_n_nxt;
            gain_n_r  <= gain_n_nxt;
        end
    end
    property p_single_upper;
        pix_valid_out && !double_mode_in |-> pix_data_out[PIX_W-1:24] == '0;
    endproperty
    a_single_upper: assert property (p_single_upper)
        else $error("second pixel bits set in single mode");
    property p_hold;
        pix_valid_out && !pix_ready_in |=> pix_valid_out && $stable(pix_data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed or withdrawn before taken");
    property p_unlocked;
        !frame_locked_out |-> !pix_valid_out;
    endproperty
    a_unlocked: assert property (p_unlocked)
        else $error("word offered before vertical sync");
    property p_clamp_len;
        $fell(adc_clamp_pulse_out) |-> clamp_n_r == 5'h08;
    endproperty
    a_clamp_len: assert property (p_clamp_len)
        else $error("clamp pulse length wrong");
    property p_gain_len;
        $fell(adc_gain_cal_pulse_out) |-> gain_n_r == 5'h10;
    endproperty
    a_gain_len: assert property (p_gain_len)
        else $error("gain pulse length wrong");
    property p_ovf_sticky;
        overflow_out && !overflow_clr_in |=> overflow_out;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag lost without clear");
    property p_ovf_clear;
        overflow_clr_in && !pix_valid_out |=> !overflow_out;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow flag not cleared");
    property p_lock;
        $rose(frame_locked_out) |-> $past(vertical_sync_input_in, 6) && !vertical_sync_input_in;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock without vertical sync trailing edge");
endmodule // rvc_capture_props

bind rvc_capture rvc_capture_props #(.PIX_W(PIX_W)) u_props (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .input_sample_clock_in(input_sample_clock_in),
    .vertical_sync_input_in(vertical_sync_input_in), .double_mode_in(double_mode_in),
    .overflow_clr_in(overflow_clr_in), .pix_ready_in(pix_ready_in),
    .pix_data_out(pix_data_out), .pix_valid_out(pix_valid_out),
    .adc_clamp_pulse_out(adc_clamp_pulse_out), .adc_gain_cal_pulse_out(adc_gain_cal_pulse_out),
    .frame_locked_out(frame_locked_out), .overflow_out(overflow_out));

/* File: rvc_defs.svh */
// constants for the rgb video input capture block
`ifndef RVC_DEFS_SVH
`define RVC_DEFS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define RVC_CNT_W       12
`define RVC_COLOR_W     8
`define RVC_PIX_W       48
`define RVC_ONE_PIX_W   24
`define RVC_PIN_W       51

// ****************************************************************
// positions inside the synchroniser vector
// ****************************************************************
`define RVC_POS_SCLK    50
`define RVC_POS_VS      49
`define RVC_POS_HS      48
`define RVC_POS_SECOND  24

// ****************************************************************
// calibration pulse lengths, in input sample clocks
// ****************************************************************
`define RVC_CLAMP_LEN   8'h08
`define RVC_GAIN_LEN    8'h10
`define RVC_PULSE_W     8

`endif

/* File: rvc_pix_if.sv */
// valid/ready pixel stream between capture logic and buffer
interface rvc_pix_if #(
    parameter int W = 48
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    // producer end
    modport src (output valid, output data, input ready);
    // consumer end
    modport snk (input valid, input data, output ready);
endinterface : rvc_pix_if

/* File: rvc_pkg.sv */
// types shared by the rgb video input capture block
package rvc_pkg;

    // capture mode, selected by a plain port
    typedef enum logic [0:0] {
        RVC_SINGLE = 1'b0,
        RVC_DOUBLE = 1'b1
    } rvc_mode_t;

endpackage : rvc_pkg

/* File: rvc_skid_buf.sv */
// two-entry pixel buffer with valid and ready on both sides
module rvc_skid_buf #(
    parameter int W = 48
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // streams
    rvc_pix_if.snk    in_if,
    rvc_pix_if.src    out_if
);
    logic         main_v_r;
    logic         main_v_nxt;
    logic [W-1:0] main_d_r;
    logic [W-1:0] main_d_nxt;
    logic         skid_v_r;
    logic         skid_v_nxt;
    logic [W-1:0] skid_d_r;
    logic [W-1:0] skid_d_nxt;
    logic         push;
    logic         pop;

    // ready drops only when both entries hold a word
    assign in_if.ready  = ~skid_v_r;
    assign out_if.valid = main_v_r;
    assign out_if.data  = main_d_r;
    assign push         = in_if.valid & ~skid_v_r;
    assign pop          = main_v_r & out_if.ready;

    // next entry contents; skid refills the head first to keep order
    always_comb begin
        main_v_nxt = main_v_r;
        main_d_nxt = main_d_r;
        skid_v_nxt = skid_v_r;
        skid_d_nxt = skid_d_r;
        if (!main_v_r || pop) begin
            if (skid_v_r) begin
                main_d_nxt = skid_d_r;
                main_v_nxt = 1'b1;
                skid_v_nxt = 1'b0;
            end else begin
                main_d_nxt = in_if.data;
                main_v_nxt = push;
            end
        end else if (push) begin
            skid_d_nxt = in_if.data;
            skid_v_nxt = 1'b1;
        end
    end

    // entry registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            main_v_r <= 1'b0;
            main_d_r <= '0;
            skid_v_r <= 1'b0;
            skid_d_r <= '0;
        end else begin
            main_v_r <= main_v_nxt;
            main_d_r <= main_d_nxt;
            skid_v_r <= skid_v_nxt;
            skid_d_r <= skid_d_nxt;
        end
    end
endmodule // rvc_skid_buf

/* File: testbench.sv */
// self-checking bench for the rgb video input capture block
`include "rvc_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_b;
    logic        dbl;
    logic [11:0] h_off;
    logic [11:0] v_off;
    logic [11:0] h_sz;
    logic [11:0] v_sz;
    logic        ovf_clr;
    logic        rdy;
    logic        sclk;
    logic        vs;
    logic        hs;
    logic [23:0] abc;
    logic [23:0] def;
    logic [47:0] data;
    logic        valid;
    logic        locked;
    logic        ovf;
    logic        clamp;
    logic        gain;
    logic [47:0] exp_q[$];
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          clamp_hi = 0;
    int          gain_hi = 0;
    rvc_adc_model adc (.sclk_out(sclk), .vs_out(vs), .hs_out(hs), .abc_out(abc), .def_out(def));
    rvc_capture uut (
        .clk_in(clk), .rst_b_in(rst_b), .input_sample_clock_in(sclk),
        .first_pixel_red_port_in(abc[23:16]), .first_pixel_green_port_in(abc[15:8]),
        .first_pixel_blue_port_in(abc[7:0]), .second_pixel_red_port_in(def[23:16]),
        .second_pixel_green_port_in(def[15:8]), .second_pixel_blue_port_in(def[7:0]),
        .vertical_sync_input_in(vs), .horizontal_sync_input_in(hs), .double_mode_in(dbl),
        .h_offset_in(h_off), .v_offset_in(v_off), .h_size_in(h_sz), .v_size_in(v_sz),
        .overflow_clr_in(ovf_clr), .pix_ready_in(rdy), .pix_data_out(data),
        .pix_valid_out(valid), .adc_clamp_pulse_out(clamp), .adc_gain_cal_pulse_out(gain),
        .frame_locked_out(locked), .overflow_out(ovf));
    // 125 MHz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // compare a pixel word
    task automatic chk_word(input string what, input logic [47:0] e, input logic [47:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    // compare a flag
    task automatic chk_bit(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask
    // take each handed-over word in order; cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (valid === 1'b1 && rdy === 1'b1) begin
            if (exp_q.size() > 0) chk_word("pixel word", exp_q.pop_front(), data);
            else chk_bit("extra word", 1'b0, valid);
        end
        // cycles spent high by each calibration pulse
        if (clamp === 1'b1) clamp_hi++;
        if (gain === 1'b1) gain_hi++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    // set mode and window, then let the values land
    task automatic set_win(input logic m, input logic [11:0] ho, hz, vo, vz);
        @(posedge clk);
        dbl <= m;
        h_off <= ho;
        h_sz <= hz;
        v_off <= vo;
        v_sz <= vz;
        @(posedge clk);
    endtask
    // queue the words a frame should give inside the window
    task automatic expect_frame(input int lines);
        for (int l = 1; l <= lines; l++)
            for (int k = 0; k < 8; k++)
                if (l >= v_off && l < v_off + v_sz && k >= h_off && k < h_off + h_sz)
                    exp_q.push_back({dbl ? {8'(k), 8'(l), 8'hc3} : 24'h00_0000,
                                     8'(l), 8'(k), 8'h5a});
    endtask
    // play a frame and confirm every queued word came out
    task automatic run_frame(input bit with_vs, input int lines);
        adc.send_frame(with_vs, lines);
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge clk);
        chk_bit("words left", 1'b1, exp_q.size() == 0);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    // no vertical sync since reset: nothing comes out, no lock
    task automatic t_no_lock;
        int g0;
        set_win(1'b0, 12'h000, 12'h008, 12'h001, 12'h003);
        g0 = gain_hi;
        run_frame(1'b0, 3);
        chk_bit("locked", 1'b0, locked);
        chk_bit("gain idle", 1'b1, gain_hi == g0);
    endtask
    // single mode, window clear of both syncs
    task automatic t_single;
        int c0;
        int g0;
        set_win(1'b0, 12'h002, 12'h003, 12'h002, 12'h002);
        expect_frame(3);
        c0 = clamp_hi;
        g0 = gain_hi;
        run_frame(1'b1, 3);
        chk_bit("locked", 1'b1, locked);
        // pulse spans len sample periods of 20 clocks, less the 10 before the first rise
        chk_bit("clamp len", 1'b1, clamp_hi - c0 == 3 * (`RVC_CLAMP_LEN * 20 - 10));
        chk_bit("gain len", 1'b1, gain_hi - g0 == `RVC_GAIN_LEN * 20 - 10);
    endtask
    // double mode pairs from the first clock after the line sync
    task automatic t_double;
        set_win(1'b1, 12'h000, 12'h008, 12'h001, 12'h001);
        expect_frame(2);
        run_frame(1'b1, 2);
    endtask
    // only the last pixel of the last line
    task automatic t_corner;
        set_win(1'b0, 12'h007, 12'h001, 12'h003, 12'h001);
        expect_frame(3);
        run_frame(1'b1, 3);
    endtask
    // receiver stalls: two words kept, the third dropped and flagged
    task automatic t_stall;
        set_win(1'b0, 12'h000, 12'h003, 12'h001, 12'h001);
        rdy <= 1'b0;
        expect_frame(2);
        void'(exp_q.pop_back());
        adc.send_frame(1'b1, 2);
        chk_bit("overflow", 1'b1, ovf);
        @(posedge clk);
        rdy <= 1'b1;
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
        chk_bit("words left", 1'b1, exp_q.size() == 0);
        ovf_clr <= 1'b1;
        @(posedge clk);
        ovf_clr <= 1'b0;
        @(posedge clk);
        chk_bit("overflow", 1'b0, ovf);
    endtask
    // second reset in mid-run drops the lock
    task automatic t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit("locked", 1'b0, locked);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // closing report
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        dbl = 1'b0;
        h_off = 12'h000;
        v_off = 12'h000;
        h_sz = 12'h000;
        v_sz = 12'h000;
        ovf_clr = 1'b0;
        rdy = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_no_lock();
        t_single();
        t_double();
        t_corner();
        t_stall();
        t_reset();
        t_no_lock();
        t_single();
        print_verdict();
    end
endmodule // testbench
